// [core/vcode_pkg.sv]
package vcode_pkg;

	// ------------------------------------------------------------------
	// code and level layout
	// ------------------------------------------------------------------
	localparam int          CODE_W      = 6;
	localparam int          LEVEL_W     = 8;
	localparam logic [5:0]  LOWEST_CODE = 6'h14;  // code of the lowest level
	localparam logic [5:0]  OFF_CODE_A  = 6'h3f;  // all ones
	localparam logic [5:0]  OFF_CODE_B  = 6'h3e;  // all ones, half step clear
	localparam logic [6:0]  WRAP_BASE   = 7'h52;  // past the wrap, minus off
	localparam logic [7:0]  BASE_LEVEL  = 8'h43;  // lowest level, 12.5mV units
	localparam logic [7:0]  ZERO_LEVEL  = 8'h00;
	localparam logic [7:0]  ONE_STEP    = 8'h01;

	// ------------------------------------------------------------------
	// timing counts, in switching cycles unless named otherwise
	// ------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS     = 50;
	localparam logic [2:0]  STROBES_PER_CYCLE = 3'h6;
	localparam logic [2:0]  LAST_MID_STROBE   = 3'h5;
	localparam int          SS_DELAY_CYCLES   = 64;
	localparam int          SS_STEP_CYCLES    = 16;
	localparam logic [1:0]  OFF_DELAY_CYCLES  = 2'h2;
	localparam int          CYC_W             = 7;

	// ------------------------------------------------------------------
	// stepper states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF,
		ST_DELAY,
		ST_RAMP,
		ST_RUN,
		ST_WAIT,
		ST_OFF_PEND
	} stepper_state_type;

	// off request decode
	function automatic logic is_off_code(input logic [5:0] code);
		is_off_code = (code == OFF_CODE_A) || (code == OFF_CODE_B);
	endfunction

	// code to level in 12.5mV units; codes wrap downward from LOWEST_CODE
	function automatic logic [7:0] decode_level(input logic [5:0] code);
		logic [6:0] idx;
		idx = 7'h00;
		if (code <= LOWEST_CODE) begin
			idx = {1'b0, LOWEST_CODE} - {1'b0, code};
		end else begin
			idx = WRAP_BASE - {1'b0, code};
		end
		decode_level = BASE_LEVEL + {1'b0, idx};
	endfunction

endpackage

// [core/cycle_strobe_gen.sv]
`timescale 1ns/10ps
// measures the switching cycle and spreads six sampling strobes over it
module cycle_strobe_gen #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             sys_rst_in,
	// pulse termination event, one cycle
	input  wire logic             cycle_event_in,
	// timing outputs
	output logic                  sample_strobe_out,
	output logic                  period_valid_out,
	output logic [CNT_W-1:0]      half_period_out
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] period;
		logic [CNT_W+2:0] acc;
		logic [2:0]       mid;
		logic             seen;
		logic             valid;
		logic             strobe;
	} timer_state_type;

	timer_state_type q;
	timer_state_type d;
	logic [CNT_W+2:0] acc_next;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// the accumulator adds six per clock and wraps at the period, so the
	// strobes stay evenly spaced without a divider
	always_comb begin
		d = q;
		d.strobe = 1'b0;
		acc_next = q.acc + {{CNT_W{1'b0}}, vcode_pkg::STROBES_PER_CYCLE};
		if (cycle_event_in) begin
			d.period = q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
			d.cnt    = '0;
			d.acc    = '0;
			d.mid    = 3'h0;
			d.seen   = 1'b1;
			d.valid  = q.seen;  // first event only opens the window
			d.strobe = q.seen;
		end else begin
			if (q.cnt != {CNT_W{1'b1}}) begin
				d.cnt = q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
			end
			// cap mid-cycle strobes at five so each cycle has exactly six
			if (q.valid && q.mid < vcode_pkg::LAST_MID_STROBE) begin
				if (acc_next >= {3'h0, q.period}) begin
					d.acc    = acc_next - {3'h0, q.period};
					d.mid    = q.mid + 3'h1;
					d.strobe = 1'b1;
				end else begin
					d.acc = acc_next;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sample_strobe_out = q.strobe;
	assign period_valid_out  = q.valid;
	assign half_period_out   = q.period >> 1;

endmodule // cycle_strobe_gen

// [core/voltage_code_dac_stepper.sv]
`timescale 1ns/10ps
module voltage_code_dac_stepper #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// code pins from the processor
	input  wire logic        code_bit4_in,
	input  wire logic        code_bit3_in,
	input  wire logic        code_bit2_in,
	input  wire logic        code_bit1_in,
	input  wire logic        code_bit0_in,
	input  wire logic        half_step_bit_in,
	// phase one pwm, falling edge marks pulse termination
	input  wire logic        phase_one_output_in,
	// reference and status
	output logic [7:0]       reference_level_out,
	output logic [7:0]       target_level_out,
	output logic             shutdown_out,
	output logic             soft_start_out,
	output logic             regulating_out,
	output logic             step_wait_out
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [6:0]                    sync1;
		logic [6:0]                    sync2;
		logic                          phase_prev;
		vcode_pkg::stepper_state_type  st;
		logic [7:0]                    level;
		logic [7:0]                    target;
		logic                          dir_up;
		logic [CNT_W-1:0]              wait_cnt;
		logic [vcode_pkg::CYC_W-1:0]   cyc_cnt;
		logic [1:0]                    off_cnt;
	} stepper_reg_type;

	// the code pins idle high through their pull-ups, so the synchroniser
	// resets to the off code and reset never invents a wake-up request
	localparam stepper_reg_type Q_RESET = '{
		sync1   : {1'b0, vcode_pkg::OFF_CODE_A},
		sync2   : {1'b0, vcode_pkg::OFF_CODE_A},
		st      : vcode_pkg::ST_OFF,
		default : '0
	};

	stepper_reg_type q;
	stepper_reg_type d;

	logic             cycle_event;
	logic             strobe;
	logic             period_valid;
	logic [CNT_W-1:0] half_period;
	logic [5:0]       code_now;
	logic             code_off;
	logic [7:0]       code_level;
	logic             far_up;
	logic             far_down;

	// ------------------------------------------------------------------
	// cycle timing
	// ------------------------------------------------------------------
	// pulse termination is the falling edge of the synchronised phase one
	assign cycle_event = q.phase_prev & ~q.sync2[6];

	cycle_strobe_gen #(
		.CNT_W (CNT_W)
	) u_timer (
		.mclk_in           (mclk_in),
		.sys_rst_in        (sys_rst_in),
		.cycle_event_in    (cycle_event),
		.sample_strobe_out (strobe),
		.period_valid_out  (period_valid),
		.half_period_out   (half_period)
	);

	// ------------------------------------------------------------------
	// code decode from the second synchroniser stage only
	// ------------------------------------------------------------------
	assign code_now   = q.sync2[5:0];
	assign code_off   = vcode_pkg::is_off_code(code_now);
	assign code_level = vcode_pkg::decode_level(code_now);

	// more than one step away from the present reference
	assign far_up   = code_level > (q.level + vcode_pkg::ONE_STEP);
	assign far_down = (code_level + vcode_pkg::ONE_STEP) < q.level;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		// two flops on every pin before any logic reads it
		d.sync1 = {phase_one_output_in, code_bit4_in, code_bit3_in,
			code_bit2_in, code_bit1_in, code_bit0_in,
			half_step_bit_in};
		d.sync2      = q.sync1;
		d.phase_prev = q.sync2[6];

		// outside ST_OFF the requested code is only taken at the sampling strobes; an off
		// code leaves the last level in place
		if (strobe && !code_off) begin
			d.target = code_level;
		end

		case (q.st)
			vcode_pkg::ST_OFF: begin
				// pwm is parked here, so the code is watched directly
				// rather than waiting for strobes that may never come
				d.level   = vcode_pkg::ZERO_LEVEL;
				d.cyc_cnt = '0;
				if (!code_off) begin
					d.target = code_level;
					d.st     = vcode_pkg::ST_DELAY;
				end
			end
			vcode_pkg::ST_DELAY: begin
				if (cycle_event) begin
					if (q.cyc_cnt == vcode_pkg::CYC_W'(
						vcode_pkg::SS_DELAY_CYCLES - 1)) begin
						d.cyc_cnt = '0;
						d.st      = vcode_pkg::ST_RAMP;
					end else begin
						d.cyc_cnt = q.cyc_cnt + 1'b1;
					end
				end
			end
			vcode_pkg::ST_RAMP: begin
				// linear climb from zero, one unit per fixed cycle count
				if (cycle_event) begin
					if (q.cyc_cnt == vcode_pkg::CYC_W'(
						vcode_pkg::SS_STEP_CYCLES - 1)) begin
						d.cyc_cnt = '0;
						if (q.level + vcode_pkg::ONE_STEP >= q.target) begin
							d.level = q.target;
							d.st    = vcode_pkg::ST_RUN;
						end else begin
							d.level = q.level + vcode_pkg::ONE_STEP;
						end
					end else begin
						d.cyc_cnt = q.cyc_cnt + 1'b1;
					end
				end
			end
			vcode_pkg::ST_RUN: begin
				if (strobe && period_valid && !code_off) begin
					if (far_up) begin
						d.level = q.level + vcode_pkg::ONE_STEP;
					end else if (far_down) begin
						d.level = q.level - vcode_pkg::ONE_STEP;
					end else if (code_level != q.level) begin
						d.dir_up   = code_level > q.level;
						d.wait_cnt = '0;
						d.st       = vcode_pkg::ST_WAIT;
					end
				end
			end
			vcode_pkg::ST_WAIT: begin
				d.wait_cnt = q.wait_cnt + 1'b1;
				// a reversal or a return to the level cancels the step
				if ((q.dir_up && q.target <= q.level) ||
					(!q.dir_up && q.target >= q.level)) begin
					d.st = vcode_pkg::ST_RUN;
				end else if (q.wait_cnt + 1'b1 >= half_period) begin
					d.st = vcode_pkg::ST_RUN;
					if (q.dir_up) begin
						d.level = q.level + vcode_pkg::ONE_STEP;
					end else begin
						d.level = q.level - vcode_pkg::ONE_STEP;
					end
				end
			end
			vcode_pkg::ST_OFF_PEND: begin
				// hold the reference two cycles before shutting down; a
				// normal code in the meantime does not cancel the shutdown
				if (cycle_event) begin
					if (q.off_cnt + 2'h1 == vcode_pkg::OFF_DELAY_CYCLES) begin
						d.st    = vcode_pkg::ST_OFF;
						d.level = vcode_pkg::ZERO_LEVEL;
					end else begin
						d.off_cnt = q.off_cnt + 2'h1;
					end
				end
			end
			default: begin
				d.st = vcode_pkg::ST_OFF;
			end
		endcase

		// an off code taken at a strobe overrides any active state
		if (strobe && code_off && q.st != vcode_pkg::ST_OFF &&
			q.st != vcode_pkg::ST_OFF_PEND) begin
			d.off_cnt = 2'h0;
			d.st      = vcode_pkg::ST_OFF_PEND;
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			q <= Q_RESET;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign reference_level_out = q.level;
	assign target_level_out    = q.target;
	assign shutdown_out        = (q.st == vcode_pkg::ST_OFF);
	assign soft_start_out      = (q.st == vcode_pkg::ST_DELAY) ||
		(q.st == vcode_pkg::ST_RAMP);
	assign regulating_out      = (q.st == vcode_pkg::ST_RUN) ||
		(q.st == vcode_pkg::ST_WAIT) || (q.st == vcode_pkg::ST_OFF_PEND);
	assign step_wait_out       = (q.st == vcode_pkg::ST_WAIT);

endmodule // voltage_code_dac_stepper

// [verif/vcode_checker.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// stepper output checks
// ----------------------------------------------------------------
module vcode_checker #(
	parameter int CNT_W = 16
) (
	input wire logic       mclk_in,
	input wire logic       sys_rst_in,
	input wire logic       code_bit4_in,
	input wire logic       code_bit3_in,
	input wire logic       code_bit2_in,
	input wire logic       code_bit1_in,
	input wire logic       code_bit0_in,
	input wire logic       half_step_bit_in,
	input wire logic       phase_one_output_in,
	input wire logic [7:0] reference_level_out,
	input wire logic [7:0] target_level_out,
	input wire logic       shutdown_out,
	input wire logic       soft_start_out,
	input wire logic       regulating_out,
	input wire logic       step_wait_out
);
	logic [5:0]       pins;
	logic             ph_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] per_q;
	logic [CNT_W-1:0] wt_q;

	assign pins = {code_bit4_in, code_bit3_in, code_bit2_in,
		code_bit1_in, code_bit0_in, half_step_bit_in};

	// period between falls and length of the current wait
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ph_q  <= 1'b0;
			cnt_q <= '0;
			per_q <= '0;
			wt_q  <= '0;
		end else begin
			ph_q  <= phase_one_output_in;
			cnt_q <= (ph_q && !phase_one_output_in) ? '0 : cnt_q + 1'b1;
			if (ph_q && !phase_one_output_in)
				per_q <= cnt_q + 1'b1;
			wt_q  <= step_wait_out ? wt_q + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	// shutdown entry may drop the level in one go, nothing else may
	a_step_by_one: assert property ($changed(reference_level_out) &&
		!shutdown_out |-> reference_level_out ==
		$past(reference_level_out) + 8'h01 || reference_level_out ==
		$past(reference_level_out) - 8'h01) else $error("level jumped");
	a_off_zero: assert property (shutdown_out
		|-> reference_level_out == 8'h00) else $error("level in off");
	a_one_mode: assert property ($onehot({shutdown_out,
		soft_start_out, regulating_out})) else $error("mode clash");
	a_wait_in_reg: assert property (step_wait_out |-> regulating_out)
		else $error("wait outside run");
	a_wait_hold: assert property (step_wait_out && $past(step_wait_out)
		|-> $stable(reference_level_out)) else $error("step in wait");
	a_wait_bound: assert property (step_wait_out && per_q != '0
		|-> wt_q <= (per_q >> 1) + 2) else $error("wait too long");
	a_code_wakes: assert property (shutdown_out && pins != 6'h3f &&
		pins != 6'h3e && $stable(pins) && pins == $past(pins, 2) &&
		!$past(sys_rst_in) |-> ##[1:3] soft_start_out)
		else $error("no restart");
	a_ref_range: assert property (regulating_out |->
		reference_level_out >= 8'h43 && reference_level_out <= 8'h80)
		else $error("level out of range");

	c_wait: cover property ($rose(step_wait_out));
	c_cancel: cover property ($fell(step_wait_out) &&
		$stable(reference_level_out));
	c_off: cover property ($rose(shutdown_out));
endmodule // vcode_checker

// [verif/cpu_code_source.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// processor code lines and phase one pwm
// ----------------------------------------------------------------
module cpu_code_source #(
	parameter int PERIOD = 48
) (
	input  wire logic       mclk_in,
	input  wire logic [5:0] code_in,
	output logic [5:0]      pins_out,
	output logic            phase_out
);
	int unsigned ph_cnt = 0;

	initial pins_out = 6'h14;

	// lines follow the request just after an edge; single steps unless
	// the bench jumps on purpose to exercise catch-up
	always @(posedge mclk_in) begin
		pins_out <= code_in;
		ph_cnt   <= (ph_cnt == PERIOD - 1) ? 0 : ph_cnt + 1;
	end

	// low for the forced third after each termination
	assign phase_out = (ph_cnt >= PERIOD / 3);
endmodule // cpu_code_source

// [verif/tb.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bench for the code stepper
// ----------------------------------------------------------------
module tb;
	logic       mclk_in = 1'b0;
	logic       sys_rst_in = 1'b1;
	logic [5:0] code_q = 6'h14;
	logic [5:0] pins;
	logic       phase;
	logic [7:0] ref_lvl;
	logic [7:0] tgt_lvl;
	logic       shut, ss, reg_on, wt;
	logic [3:0] stat;
	logic [5:0] c;
	int         failures = 0;
	int         n_tests = 0;
	int         cnt;

	assign stat = {ss, shut, reg_on, wt};

	// 20 MHz
	always #25 mclk_in = ~mclk_in;

	cpu_code_source #(.PERIOD(48)) u_cpu (.mclk_in(mclk_in),
		.code_in(code_q), .pins_out(pins), .phase_out(phase));

	voltage_code_dac_stepper u_dut (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.code_bit4_in(pins[5]), .code_bit3_in(pins[4]),
		.code_bit2_in(pins[3]), .code_bit1_in(pins[2]),
		.code_bit0_in(pins[1]), .half_step_bit_in(pins[0]),
		.phase_one_output_in(phase),
		.reference_level_out(ref_lvl), .target_level_out(tgt_lvl),
		.shutdown_out(shut), .soft_start_out(ss),
		.regulating_out(reg_on), .step_wait_out(wt));

	// level counts down from the lowest code, then from the wrap
	function automatic logic [7:0] lvl_of(input logic [5:0] k);
		return (k <= 6'h14) ? 8'h57 - {2'h0, k} : 8'h95 - {2'h0, k};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (failures == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic set_code(input logic [5:0] k);
		@(posedge mclk_in);
		code_q <= k;
	endtask

	// bounded waits sample at the falling edge, clear of update races
	task automatic wait_lvl(input logic [7:0] exp, input int lim);
		cnt = 0;
		while (ref_lvl !== exp && cnt < lim) begin
			@(negedge mclk_in);
			cnt++;
		end
		check(ref_lvl, exp);
		if (ref_lvl !== exp) give_verdict();
	endtask

	task automatic wait_hi(input int sel, input int lim);
		cnt = 0;
		while (stat[sel] !== 1'b1 && cnt < lim) begin
			@(negedge mclk_in);
			cnt++;
		end
		check({7'h0, stat[sel]}, 8'h01);
		if (stat[sel] !== 1'b1) give_verdict();
	endtask

	// main sequence
	initial begin
		void'($urandom(32'hf61a2b73));
		repeat (10) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		repeat (5) @(negedge mclk_in);
		check({7'h0, ss}, 8'h01);
		wait_hi(1, 70000);
		check(ref_lvl, 8'h43);
		set_code(6'h13);
		wait_hi(0, 60);
		wait_lvl(8'h44, 60);
		check({7'h0, cnt >= 22 && cnt <= 26}, 8'h01);
		// return to the level inside the wait must cancel the step
		set_code(6'h12);
		wait_hi(0, 60);
		set_code(6'h13);
		repeat (60) @(negedge mclk_in);
		check(ref_lvl, 8'h44);
		for (int k = 0; k < 62; k++) begin
			set_code(6'(k));
			repeat (14) @(negedge mclk_in);
			check(tgt_lvl, lvl_of(6'(k)));
		end
		wait_lvl(8'h58, 800);
		// widest jump, bottom to top, then random jumps
		set_code(6'h14);
		wait_lvl(8'h43, 800);
		set_code(6'h15);
		wait_lvl(8'h80, 800);
		check({7'h0, cnt >= 400 && cnt <= 560}, 8'h01);
		repeat (6) begin
			c = 6'($urandom_range(61));
			set_code(c);
			wait_lvl(lvl_of(c), 800);
		end
		set_code(6'h3e);
		wait_hi(2, 200);
		check(ref_lvl, 8'h00);
		set_code(6'h3f);
		repeat (10) @(negedge mclk_in);
		check({7'h0, shut}, 8'h01);
		set_code(6'h14);
		repeat (6) @(negedge mclk_in);
		check({7'h0, ss}, 8'h01);
		give_verdict();
	end
endmodule // tb

bind voltage_code_dac_stepper vcode_checker #(.CNT_W(CNT_W)) u_chk (
	.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
	.code_bit4_in(code_bit4_in), .code_bit3_in(code_bit3_in),
	.code_bit2_in(code_bit2_in), .code_bit1_in(code_bit1_in),
	.code_bit0_in(code_bit0_in), .half_step_bit_in(half_step_bit_in),
	.phase_one_output_in(phase_one_output_in),
	.reference_level_out(reference_level_out),
	.target_level_out(target_level_out), .shutdown_out(shutdown_out),
	.soft_start_out(soft_start_out), .regulating_out(regulating_out),
	.step_wait_out(step_wait_out));
